// ### core/usart_receiver_core.sv
// Serial receive channel with line format control, receive buffer,
// status flags and two interrupt pulse outputs, on an Avalon-MM slave.
// Assumes rx_clk and rx_serial are synchronous to clock.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module usart_receiver_core (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        rx_clk,
  input  wire logic        rx_serial,
  input  wire logic        tx_off_turnaround,
  output logic             irq_full,
  output logic             irq_error
);
  typedef enum logic [2:0] {IDLE, DATA, PAR, STOP1, STOP2} rx_state_t;

  rx_state_t  st_q;
  logic       wait_q;
  logic [7:0] rdata_q;
  logic [7:0] cfg_q;
  logic [7:0] sync_pat_q;
  logic [1:0] chan_q;
  logic       strip_q;
  logic       rx_on_q;
  logic [7:0] shreg_q;
  logic [8:0] win_q;
  logic [2:0] cnt_q;
  logic       par_q;
  logic [3:0] ones_q;
  logic       brk_line_q;
  logic       wd_q;
  logic [7:0] wd_data_q;
  logic       wd_perr_q;
  logic       wd_ferr_q;
  logic       wd_brk_q;
  logic       wd_match_q;
  logic       found_evt_q;
  logic [7:0] buf_q;
  logic       full_q;
  logic       ovr_q;
  logic       perr_q;
  logic       ferr_q;
  logic       brk_q;
  logic       brk_ack_q;
  logic       found_q;
  logic       match_q;
  logic       underway_q;
  logic       pend_ovr_q;
  logic       pend_brk_q;
  logic       irq_full_q;
  logic       irq_err_q;
  logic       bit_stb;
  logic       bit_val;

  // Bus decode
  wire req      = read | write;
  wire done     = req & ~wait_q;
  wire hit_cfg  = address == usart_rx_pkg::CFG_ADDR;
  wire hit_stat = address == usart_rx_pkg::STAT_ADDR;
  wire hit_data = address == usart_rx_pkg::DATA_ADDR;
  wire hit_sync = address == usart_rx_pkg::SYNC_ADDR;
  wire hit_chan = address == usart_rx_pkg::CHAN_ADDR;
  wire wr_ok    = write & done & byteenable[0];
  wire rd_data  = read & done & hit_data;
  wire rd_stat  = read & done & hit_stat;
  wire wr_stat  = wr_ok & hit_stat;

  // Line format decode
  wire       div16    = cfg_q[usart_rx_pkg::CFG_DIV16];
  wire [1:0] wl       = cfg_q[usart_rx_pkg::CFG_WL_HI:usart_rx_pkg::CFG_WL_LO];
  wire [1:0] fmt      = cfg_q[usart_rx_pkg::CFG_FMT_HI:usart_rx_pkg::CFG_FMT_LO];
  wire       par_en   = cfg_q[usart_rx_pkg::CFG_PAR_EN];
  wire       even     = cfg_q[usart_rx_pkg::CFG_EVEN];
  wire       wake     = cfg_q[usart_rx_pkg::CFG_WAKE];
  wire       sync_fmt = fmt == usart_rx_pkg::FMT_SYNC;
  wire [2:0] last_bit = 3'h7 - {1'b0, wl};
  wire       two_stop = (fmt == usart_rx_pkg::FMT_TWO) | (fmt == usart_rx_pkg::FMT_ONE_HALF);
  wire       line_idle = ones_q == usart_rx_pkg::IDLE_ONES;

  // Receiver runs while enabled and no overrun awaits its status read
  wire run      = rx_on_q & ~ovr_q;
  wire go_bit   = bit_stb & run;
  wire fs_wr0   = wr_stat & sync_fmt & ~writedata[usart_rx_pkg::ST_FSB];

  // Sync window: last word length (plus parity) bits against the pattern; the parity bit is left out for eight-bit words
  wire [8:0] win_n    = {bit_val, win_q[8:1]};
  wire [3:0] sync_len = {1'b0, last_bit} + 4'h1 + {3'h0, par_en};
  wire [8:0] win_sh   = win_n >> (4'h9 - sync_len);
  wire [8:0] win_mask = (9'h1ff >> (4'h9 - sync_len)) & 9'h0ff;
  wire       win_hit  = ((win_sh ^ {1'b0, sync_pat_q}) & win_mask) == 9'h000;

  wire       perr_now = (par_q ^ bit_val) == even;
  wire       last_dat = cnt_q == last_bit;
  wire       data_end = (st_q == DATA) & last_dat & ~par_en;
  wire       par_end  = st_q == PAR;

  // Delivery of an assembled word
  wire discard  = sync_fmt & strip_q & wd_match_q;
  wire accept   = wd_q & ~wake & ~discard & rx_on_q;
  wire can_load = ~full_q | rd_data;
  wire load     = accept & can_load;
  wire lost     = accept & ~can_load;
  wire set_ovr  = rd_data & pend_ovr_q;
  wire set_brk  = rd_data & pend_brk_q;
  wire brk_end  = brk_q & ~brk_line_q & brk_ack_q & ~sync_fmt;
  wire err_word = wd_perr_q | wd_ferr_q | wd_brk_q;
  wire err_evt  = (load & err_word) | set_ovr | set_brk | brk_end | found_evt_q;
  wire full_evt = load & ~err_word;

  wire [7:0] stat_rd = {full_q, ovr_q, perr_q, ferr_q, sync_fmt ? found_q : brk_q,
                        sync_fmt ? match_q : underway_q, strip_q, rx_on_q};
  wire [7:0] rd_mux  = hit_cfg  ? cfg_q :
                       hit_stat ? stat_rd :
                       hit_data ? buf_q :
                       hit_sync ? sync_pat_q :
                       hit_chan ? {6'h00, chan_q} : 8'h00;

  assign readdata    = {24'h000000, rdata_q};
  assign waitrequest = wait_q;
  assign irq_full    = irq_full_q;
  assign irq_error   = irq_err_q;

  rx_bit_timer u_timer (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .rx_clk    (rx_clk),
    .rx_serial (rx_serial),
    .div16     (div16),
    .bit_stb   (bit_stb),
    .bit_val   (bit_val)
  );

  // Bus slave: one wait state, read data captured during the wait cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wait_q  <= 1'b1;
      rdata_q <= 8'h00;
    end else begin
      wait_q <= ~(req & wait_q);
      if (read && wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Software registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q      <= usart_rx_pkg::CFG_RESET;
      sync_pat_q <= usart_rx_pkg::SYNC_RESET;
      chan_q     <= usart_rx_pkg::CHAN_RESET;
      strip_q    <= 1'b0;
      rx_on_q    <= 1'b0;
    end else begin
      if (wr_ok && hit_cfg) begin
        cfg_q[7:1] <= writedata[7:1];
      end
      if (bit_stb && rx_on_q && ones_q == 4'h9 && bit_val) begin
        cfg_q[usart_rx_pkg::CFG_WAKE] <= 1'b0;
      end else if (wr_ok && hit_cfg) begin
        cfg_q[usart_rx_pkg::CFG_WAKE] <= writedata[0] & ~line_idle;
      end
      if (wr_ok && hit_sync) begin
        sync_pat_q <= writedata[7:0];
      end
      if (wr_ok && hit_chan) begin
        chan_q <= writedata[1:0];
      end
      if (wr_stat) begin
        strip_q <= writedata[usart_rx_pkg::ST_STRIP];
      end
      if (tx_off_turnaround) begin
        rx_on_q <= 1'b1;
      end else if (wr_stat) begin
        rx_on_q <= writedata[usart_rx_pkg::ST_ON];
      end
    end
  end

  // Idle line counter: consecutive ones
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ones_q <= 4'h0;
    end else if (bit_stb && rx_on_q) begin
      if (!bit_val) begin
        ones_q <= 4'h0;
      end else if (!line_idle) begin
        ones_q <= ones_q + 4'h1;
      end
    end
  end

  // Assembly state machine
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q        <= IDLE;
      shreg_q     <= 8'h00;
      win_q       <= 9'h000;
      cnt_q       <= 3'h0;
      par_q       <= 1'b0;
      brk_line_q  <= 1'b0;
      underway_q  <= 1'b0;
      found_evt_q <= 1'b0;
      wd_q        <= 1'b0;
      wd_data_q   <= 8'h00;
      wd_perr_q   <= 1'b0;
      wd_ferr_q   <= 1'b0;
      wd_brk_q    <= 1'b0;
      wd_match_q  <= 1'b0;
    end else begin
      wd_q        <= 1'b0;
      found_evt_q <= 1'b0;
      if (!run || fs_wr0) begin
        st_q <= IDLE;
        if (!rx_on_q) begin
          underway_q <= 1'b0;
          brk_line_q <= 1'b0;
        end
      end else if (go_bit) begin
        win_q <= win_n;
        if (bit_val && !sync_fmt) begin
          brk_line_q <= 1'b0;
        end
        case (st_q)
          IDLE: begin
            shreg_q <= 8'h00;
            cnt_q   <= 3'h0;
            par_q   <= 1'b0;
            if (sync_fmt) begin
              if (found_q) begin
                st_q    <= DATA;
                shreg_q <= {7'h00, bit_val};
                par_q   <= bit_val;
                cnt_q   <= 3'h1;
              end else if (win_hit) begin
                st_q        <= DATA;
                found_evt_q <= 1'b1;
              end
            end else if (!bit_val && !brk_line_q) begin
              st_q       <= DATA;
              underway_q <= 1'b1;
            end
          end
          DATA: begin
            shreg_q[cnt_q] <= bit_val;
            par_q          <= par_q ^ bit_val;
            cnt_q          <= cnt_q + 3'h1;
            if (last_dat) begin
              st_q <= par_en ? PAR : (sync_fmt ? DATA : STOP1);
              cnt_q <= 3'h0;
            end
            if (data_end && sync_fmt) begin
              wd_q       <= 1'b1;
              wd_data_q  <= shreg_q | ({7'h00, bit_val} << cnt_q);
              wd_perr_q  <= 1'b0;
              wd_ferr_q  <= 1'b0;
              wd_brk_q   <= 1'b0;
              wd_match_q <= win_hit;
              par_q      <= 1'b0;
            end
          end
          PAR: begin
            wd_perr_q <= perr_now;
            par_q     <= 1'b0;
            st_q      <= sync_fmt ? DATA : STOP1;
            if (sync_fmt) begin
              wd_q       <= 1'b1;
              wd_data_q  <= shreg_q;
              wd_ferr_q  <= 1'b0;
              wd_brk_q   <= 1'b0;
              wd_match_q <= win_hit;
            end
          end
          STOP1: begin
            wd_q       <= 1'b1;
            wd_data_q  <= shreg_q;
            wd_match_q <= 1'b0;
            wd_ferr_q  <= ~bit_val & (shreg_q != 8'h00);
            wd_brk_q   <= ~bit_val & (shreg_q == 8'h00);
            brk_line_q <= ~bit_val & (shreg_q == 8'h00);
            if (!par_en) begin
              wd_perr_q <= 1'b0;
            end
            if (bit_val && two_stop) begin
              st_q <= STOP2;
            end else begin
              st_q       <= IDLE;
              underway_q <= 1'b0;
            end
          end
          STOP2: begin
            st_q       <= IDLE;
            underway_q <= 1'b0;
          end
          default: st_q <= IDLE;
        endcase
        if (par_end && !sync_fmt) begin
          wd_perr_q <= perr_now;
        end
      end
    end
  end

  // Buffer and status flags
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      buf_q      <= 8'h00;
      full_q     <= 1'b0;
      ovr_q      <= 1'b0;
      perr_q     <= 1'b0;
      ferr_q     <= 1'b0;
      brk_q      <= 1'b0;
      brk_ack_q  <= 1'b0;
      found_q    <= 1'b0;
      match_q    <= 1'b0;
      pend_ovr_q <= 1'b0;
      pend_brk_q <= 1'b0;
    end else if (!rx_on_q) begin
      full_q     <= 1'b0;
      ovr_q      <= 1'b0;
      perr_q     <= 1'b0;
      ferr_q     <= 1'b0;
      brk_q      <= 1'b0;
      brk_ack_q  <= 1'b0;
      found_q    <= 1'b0;
      match_q    <= 1'b0;
      pend_ovr_q <= 1'b0;
      pend_brk_q <= 1'b0;
    end else begin
      full_q <= load | (full_q & ~rd_data);
      if (load) begin
        buf_q   <= wd_data_q;
        perr_q  <= wd_perr_q;
        ferr_q  <= wd_ferr_q;
        match_q <= wd_match_q;
      end
      if (lost && wd_brk_q) begin
        pend_brk_q <= 1'b1;
      end else if (rd_data) begin
        pend_brk_q <= 1'b0;
      end
      if (lost && !wd_brk_q) begin
        pend_ovr_q <= 1'b1;
      end else if (rd_data) begin
        pend_ovr_q <= 1'b0;
      end
      if (set_ovr) begin
        ovr_q <= 1'b1;
      end else if (rd_stat) begin
        ovr_q <= 1'b0;
      end
      if ((load && wd_brk_q) || set_brk) begin
        brk_q     <= 1'b1;
        brk_ack_q <= 1'b0;
      end else if (brk_end) begin
        brk_q     <= 1'b0;
        brk_ack_q <= 1'b0;
      end else if (rd_stat && brk_q) begin
        brk_ack_q <= 1'b1;
      end
      if (found_evt_q) begin
        found_q <= 1'b1;
      end else if (wr_stat && sync_fmt) begin
        found_q <= writedata[usart_rx_pkg::ST_FSB];
      end
    end
  end

  // One interrupt per event, steered by the channel enables
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_full_q <= 1'b0;
      irq_err_q  <= 1'b0;
    end else begin
      irq_err_q  <= err_evt & chan_q[usart_rx_pkg::CH_ERR_EN];
      irq_full_q <= chan_q[usart_rx_pkg::CH_FULL_EN]
                    & (full_evt | (err_evt & ~chan_q[usart_rx_pkg::CH_ERR_EN]));
    end
  end
endmodule
`default_nettype wire

// ### inc/usart_rx_pkg.sv
// Constants for the serial receive channel: register map, field layout,
// reset values and receive timing counts.
// Assumes a single system clock; every user includes it by scoped name.
//
// Summary of operation
// - Shift bits in, then move character to buffer
// - Data port read clears full, frees buffer
// - Status latched per word, held until read
// - Control bit 7 selects divide-by-16 with resync
// - Bits 6:5 give eight, seven, six, five bits
// - Bits 4:3 select synchronous or async stop bits
// - Bit 2 enables parity check
// - Bit 1 selects odd (0) or even parity
// - Wake-up bit clears after ten ones
// - One interrupt per word, errors on error channel
// - Full flag read-only, set on load, cleared on read
// - Overrun set on data read, halts until status read
// - Parity error follows each buffered word
// - Frame error: non-zero async word without stop
// - Sync search compares pattern, found sets and interrupts
// - Break flag, clears after one and status read
// - Match in sync, character underway in async
// - Sync strip discards matching words
// - Receiver enable clear disables and clears all flags
// - Break while full is no overrun
// - Start must be stable three edges
// - Resync resets at transition, samples at eight
// - Divide-by-one samples each receive clock rise
package usart_rx_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] CFG_INDEX  = 8'h29;
  localparam logic [7:0] STAT_INDEX = 8'h2b;
  localparam logic [7:0] DATA_INDEX = 8'h30;
  localparam logic [7:0] SYNC_INDEX = 8'h31;
  localparam logic [7:0] CHAN_INDEX = 8'h32;
  localparam logic [7:0] CFG_ADDR   = 8'ha4;
  localparam logic [7:0] STAT_ADDR  = 8'hac;
  localparam logic [7:0] DATA_ADDR  = 8'hc0;
  localparam logic [7:0] SYNC_ADDR  = 8'hc4;
  localparam logic [7:0] CHAN_ADDR  = 8'hc8;

  // line_format_cfg fields
  localparam int CFG_DIV16  = 7;
  localparam int CFG_WL_HI  = 6;
  localparam int CFG_WL_LO  = 5;
  localparam int CFG_FMT_HI = 4;
  localparam int CFG_FMT_LO = 3;
  localparam int CFG_PAR_EN = 2;
  localparam int CFG_EVEN   = 1;
  localparam int CFG_WAKE   = 0;

  // rx_state_flags fields
  localparam int ST_FULL  = 7;
  localparam int ST_OVR   = 6;
  localparam int ST_PERR  = 5;
  localparam int ST_FERR  = 4;
  localparam int ST_FSB   = 3;
  localparam int ST_MCIP  = 2;
  localparam int ST_STRIP = 1;
  localparam int ST_ON    = 0;

  // Channel enable register fields
  localparam int CH_ERR_EN  = 0;
  localparam int CH_FULL_EN = 1;

  localparam logic [1:0] FMT_SYNC     = 2'h0;
  localparam logic [1:0] FMT_ONE_HALF = 2'h2;
  localparam logic [1:0] FMT_TWO      = 2'h3;

  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] SYNC_RESET = 8'h00;
  localparam logic [1:0] CHAN_RESET = 2'h0;

  localparam logic [1:0] STABLE_LAST  = 2'h2;
  localparam logic [3:0] RESYNC_OPEN  = 4'h4;
  localparam logic [3:0] SAMPLE_STATE = 4'h8;
  localparam logic [3:0] IDLE_ONES    = 4'ha;

endpackage

// ### core/rx_bit_timer.sv
// Bit timing for the receiver: edge enable from the receive clock pin,
// plus divide-by-16 resynchronisation and false start filter.
// Assumes rx_clk and rx_serial are synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module rx_bit_timer (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic rx_clk,
  input  wire logic rx_serial,
  input  wire logic div16,
  output logic      bit_stb,
  output logic      bit_val
);
  logic       rxc_q;
  logic       lvl_q;
  logic [1:0] stab_q;
  logic [3:0] state_q;
  logic       stb_q;
  logic       val_q;

  wire       rise     = rx_clk & ~rxc_q;
  wire       differ   = rx_serial != lvl_q;
  wire [3:0] state_n  = state_q + 4'h1;
  // Transition valid on third stable edge, only from state four on
  wire       valid_tr = differ & (stab_q == usart_rx_pkg::STABLE_LAST)
                        & (state_q >= usart_rx_pkg::RESYNC_OPEN);

  assign bit_stb = stb_q;
  assign bit_val = val_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rxc_q   <= 1'b0;
      lvl_q   <= 1'b1;
      stab_q  <= 2'h0;
      state_q <= 4'h0;
      stb_q   <= 1'b0;
      val_q   <= 1'b1;
    end else begin
      rxc_q <= rx_clk;
      stb_q <= 1'b0;
      if (rise && !div16) begin
        stb_q <= 1'b1;
        val_q <= rx_serial;
      end else if (rise) begin
        if (valid_tr) begin
          lvl_q   <= rx_serial;
          state_q <= 4'h0;
          stab_q  <= 2'h0;
        end else begin
          stab_q  <= differ ? stab_q + 2'h1 : 2'h0;
          state_q <= state_n;
          if (state_n == usart_rx_pkg::SAMPLE_STATE) begin
            stb_q <= 1'b1;
            val_q <= lvl_q;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/usart_rx_asserts.sv
// Port-level checker for the serial receive channel.
// Assumes the one-wait-cycle bus answer and one-cycle interrupt pulses.
`timescale 1ns/1ps
`default_nettype none
module usart_rx_checker (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        rx_clk,
  input wire logic        rx_serial,
  input wire logic        tx_off_turnaround,
  input wire logic        irq_full,
  input wire logic        irq_error
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic       rx_clk_q;
  logic [3:0] bit_age_q;
  logic [3:0] bus_age_q;
  logic [3:0] bit_age_d;
  logic [3:0] bus_age_d;
  // Cycles since the last receive clock rise and the last completed access
  assign bit_age_d = (rx_clk && !rx_clk_q) ? 4'h0 : bit_age_q + {3'h0, bit_age_q != 4'hf};
  assign bus_age_d = ((read || write) && !waitrequest) ? 4'h0 :
                     bus_age_q + {3'h0, bus_age_q != 4'hf};
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_clk_q  <= 1'b0;
      bit_age_q <= 4'hf;
      bus_age_q <= 4'hf;
    end else begin
      rx_clk_q  <= rx_clk;
      bit_age_q <= bit_age_d;
      bus_age_q <= bus_age_d;
    end
  end
  wait_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered after one wait cycle");
  wait_single_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  rdata_upper_a: assert property (readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  rdata_hold_a: assert property ($changed(readdata) |-> read && !waitrequest)
    else $error("read data changed outside a read answer");
  irq_single_a: assert property (irq_full |=> !irq_full)
    else $error("full interrupt longer than one cycle");
  irq_one_chan_a: assert property (!(irq_full && irq_error))
    else $error("both interrupt channels pulsed together");
  full_cause_a: assert property (irq_full |-> bit_age_q <= 4'h8 || bus_age_q <= 4'h4)
    else $error("full interrupt without a received bit or access");
  err_cause_a: assert property (irq_error |-> bus_age_q <= 4'h4 || bit_age_q <= 4'h8)
    else $error("error interrupt without a received bit or access");
  rst_quiet_a: assert property ($fell(sys_rst) |-> waitrequest && !irq_full && !irq_error)
    else $error("outputs not at rest after reset");
  cover property (irq_full);
  cover property (irq_error);
  cover property (read && !waitrequest && address == 8'hc0);
endmodule
bind usart_receiver_core usart_rx_checker i_chk (
  .clock(clock), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .rx_clk(rx_clk), .rx_serial(rx_serial),
  .tx_off_turnaround(tx_off_turnaround), .irq_full(irq_full), .irq_error(irq_error)
);
`default_nettype wire

// ### sim/serial_tx_model.sv
// Remote transmitter: drives receive clock and serial line bit by bit.
// Assumes the caller builds the frame; the clock stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
  input  wire logic clock,
  output logic      rx_clk,
  output logic      rx_serial
);
  initial begin
    rx_clk = 1'b0;
    rx_serial = 1'b1;
  end
  // Data is set up two cycles before each rise and held three cycles after
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      rx_serial <= bits[i];
      repeat (2) @(posedge clock);
      rx_clk <= 1'b1;
      repeat (2) @(posedge clock);
      rx_clk <= 1'b0;
    end
    @(posedge clock);
    rx_serial <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### sim/usart_receiver_core_bench.sv
// Self-checking bench for the serial receive channel.
// Assumes the remote transmitter model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module usart_receiver_core_bench;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hf;
  logic        tx_off_turnaround = 1'b0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        rx_clk;
  logic        rx_serial;
  logic        irq_full;
  logic        irq_error;
  int          err_total = 0;
  int          compares = 0;
  int          n_full = 0;
  int          n_err = 0;
  int          nf;
  int          ne;
  logic [7:0]  rd;
  logic [1:0]  fmt;
  logic        p;
  always #25 clock = ~clock;
  always @(posedge clock) begin
    if (irq_full === 1'b1) n_full <= n_full + 1;
    if (irq_error === 1'b1) n_err <= n_err + 1;
  end
  usart_receiver_core i_dut (
    .clock(clock), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .rx_clk(rx_clk), .rx_serial(rx_serial),
    .tx_off_turnaround(tx_off_turnaround), .irq_full(irq_full), .irq_error(irq_error)
  );
  serial_tx_model i_far (.clock(clock), .rx_clk(rx_clk), .rx_serial(rx_serial));
  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic wait_ack;
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      if (waitrequest === 1'b0) return;
    end
    err_total++;
    $display("[FAIL] waitrequest expected 0 seen 1");
    results();
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be = 4'h1);
    @(posedge clock);
    address <= a;
    writedata <= {24'h000000, d};
    byteenable <= be;
    write <= 1'b1;
    wait_ack();
    write <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    wait_ack();
    d = readdata[7:0];
    read <= 1'b0;
  endtask
  // Async frame: start, data LSB first, optional parity, stop, then one idle one
  task automatic send_word(input logic [7:0] d, input int nd, input logic pon,
                           input logic pbit, input logic stop);
    logic [11:0] f;
    int          k;
    f = 12'h000;
    k = 1;
    for (int i = 0; i < nd; i++) begin
      f[k] = d[i];
      k++;
    end
    if (pon) begin
      f[k] = pbit;
      k++;
    end
    f[k] = stop;
    f[k+1] = 1'b1;
    i_far.send(f, k + 2);
    repeat (6) @(posedge clock);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    bus_rd(usart_rx_pkg::CFG_ADDR, rd);  chk("cfg reset", 8'h00, rd);
    bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("status reset", 8'h00, rd);
    bus_rd(8'h10, rd);                   chk("unmapped", 8'h00, rd);
    bus_wr(usart_rx_pkg::CFG_ADDR, 8'hfe, 4'he);
    bus_rd(usart_rx_pkg::CFG_ADDR, rd);  chk("cfg masked", 8'h00, rd);
    bus_wr(usart_rx_pkg::CFG_ADDR, 8'hfe);
    bus_rd(usart_rx_pkg::CFG_ADDR, rd);  chk("cfg fields", 8'hfe, rd);
    bus_wr(usart_rx_pkg::CHAN_ADDR, 8'h03);
    bus_wr(usart_rx_pkg::STAT_ADDR, 8'h01);
    for (int i = 0; i < 4; i++) begin
      fmt = (i == 3) ? 2'h1 : 2'(i + 1);
      nf = n_full;
      bus_wr(usart_rx_pkg::CFG_ADDR, {1'b0, 2'(i), fmt, 3'h0});
      send_word(8'hb5, 8 - i, 1'b0, 1'b0, 1'b1);
      chk("full irq", 8'h01, 8'(n_full - nf));
      bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("status word", 8'h81, rd);
      bus_rd(usart_rx_pkg::DATA_ADDR, rd); chk("data length", 8'hb5 & (8'hff >> i), rd);
      bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("status read", 8'h01, rd);
    end
    for (int j = 0; j < 4; j++) begin
      bus_wr(usart_rx_pkg::CFG_ADDR, 8'h0c | {6'h00, 1'(j), 1'b0});
      p = (j[0] ? ^8'h07 : ~^8'h07) ^ j[1];
      send_word(8'h07, 8, 1'b1, p, 1'b1);
      bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("parity", {2'b10, j[1], 5'h01}, rd);
      bus_rd(usart_rx_pkg::DATA_ADDR, rd); chk("data parity", 8'h07, rd);
    end
    bus_wr(usart_rx_pkg::CFG_ADDR, 8'h08);
    ne = n_err;
    send_word(8'h5a, 8, 1'b0, 1'b0, 1'b0);
    bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("frame error", 8'h91, rd);
    bus_rd(usart_rx_pkg::DATA_ADDR, rd); chk("data frame", 8'h5a, rd);
    send_word(8'h00, 8, 1'b0, 1'b0, 1'b0);
    bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("break", 8'h89, rd);
    bus_rd(usart_rx_pkg::DATA_ADDR, rd); chk("data break", 8'h00, rd);
    bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("break end", 8'h01, rd);
    chk("error irqs", 8'h03, 8'(n_err - ne));
    ne = n_err;
    send_word(8'h11, 8, 1'b0, 1'b0, 1'b1);
    send_word(8'h22, 8, 1'b0, 1'b0, 1'b1);
    bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("status kept", 8'h81, rd);
    bus_rd(usart_rx_pkg::DATA_ADDR, rd); chk("data kept", 8'h11, rd);
    bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("overrun", 8'h41, rd);
    bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("overrun cleared", 8'h01, rd);
    chk("overrun irq", 8'h01, 8'(n_err - ne));
    send_word(8'h44, 8, 1'b0, 1'b0, 1'b1);
    send_word(8'h00, 8, 1'b0, 1'b0, 1'b0);
    bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("full before break", 8'h81, rd);
    bus_rd(usart_rx_pkg::DATA_ADDR, rd); chk("data before break", 8'h44, rd);
    bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("break no overrun", 8'h09, rd);
    bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("break over", 8'h01, rd);
    bus_wr(usart_rx_pkg::CFG_ADDR, 8'h09);
    bus_rd(usart_rx_pkg::CFG_ADDR, rd);  chk("wake set", 8'h09, rd);
    send_word(8'h66, 8, 1'b0, 1'b0, 1'b1);
    bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("wake drop", 8'h01, rd);
    i_far.send(12'h3ff, 10);
    repeat (6) @(posedge clock);
    bus_rd(usart_rx_pkg::CFG_ADDR, rd);  chk("wake clear", 8'h08, rd);
    send_word(8'h77, 8, 1'b0, 1'b0, 1'b1);
    bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("full again", 8'h81, rd);
    bus_wr(usart_rx_pkg::STAT_ADDR, 8'h00);
    bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("disable", 8'h00, rd);
    @(posedge clock);
    tx_off_turnaround <= 1'b1;
    @(posedge clock);
    tx_off_turnaround <= 1'b0;
    bus_rd(usart_rx_pkg::STAT_ADDR, rd); chk("turnaround", 8'h01, rd);
    results();
  end
endmodule
`default_nettype wire
